// [hw/fec_codec_pkg.sv]
// shared constants, carriers and states of the coding path
package fec_codec_pkg;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned TX_FIFO_DEPTH = 4;
  localparam int unsigned MAT_BITS      = 16;
  localparam int unsigned NSTATES       = 8;
  localparam int unsigned SURV_LEN      = 16;
  localparam logic [1:0]  LEN_FIXED     = 2'h0;
  localparam logic [7:0]  PAD_BYTE      = 8'h00;
  localparam logic [3:0]  POLY_A_DEF    = 4'hF;
  localparam logic [3:0]  POLY_B_DEF    = 4'hB;
  localparam logic [7:0]  METRIC_START  = 8'h00;
  localparam logic [7:0]  METRIC_FAR    = 8'h3F;
  localparam logic [4:0]  CODED_BITS    = 5'h10;
  localparam logic [4:0]  PLAIN_BITS    = 5'h08;
  localparam logic [4:0]  SURV_FULL     = 5'h10;
  localparam logic [2:0]  LAST_PAIR     = 3'h7;
  localparam logic [3:0]  LAST_FLUSH    = 4'hF;
  localparam logic [3:0]  LAST_SYMBOL   = 4'hF;
  localparam logic [2:0]  LAST_BIT      = 3'h7;

  typedef struct packed {
    logic       enable;
    logic [1:0] length_mode;
    logic [7:0] length;
  } codec_cfg_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SEND = 2'b11,
    TX_DONE = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE    = 3'b000,
    RX_COLLECT = 3'b001,
    RX_DECODE  = 3'b011,
    RX_FLUSH   = 3'b010,
    RX_DONE    = 3'b110
  } rx_state_t;

  // row-major cell index of the k-th bit read down the columns
  function automatic logic [3:0] column_read(input logic [3:0] k);
    return {k[1:0], k[3:2]};
  endfunction

  function automatic logic coded_bit(input logic [3:0] window,
                                     input logic [3:0] poly);
    return ^(window & poly);
  endfunction
endpackage

// [hw/fec_interleave_codec.sv]
// transmit encoder/interleaver and receive de-interleaver/decoder
// Behaviour
// - coding is used only when error_correction_enable is 1.
// - coding holds only in fixed length mode 0, else bits pass plain.
// - the data field and CRC are coded on send and decoded on receive.
// - rate one-half coder, constraint length 4, two bits per input bit.
// - interleaving and de-interleaving always accompany the coding.
// - each direction holds a four by four bit matrix.
// - send writes coder bits by rows and transmits them by columns.
// - receive writes symbols by rows and feeds the decoder by columns.
// - at least one extra byte follows the coded field to close the trellis.
// - coded air data is a whole number of two-byte interleaver loads.
// - one or two pad bytes are added so the coded byte total is even.
// - pad bytes are dropped on receive and never reach the output.
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0]    count, next_count;
  logic             push, pop;

  always_comb begin
    in_ready    = (count != CW'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? PW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop ? PW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
    next_count  = CW'(count + CW'(push) - CW'(pop));
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage carries no reset so it can map to plain registers
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module fec_interleave_codec
  import fec_codec_pkg::*;
#(
  parameter logic [3:0] POLY_A = POLY_A_DEF,
  parameter logic [3:0] POLY_B = POLY_B_DEF
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // packet setup from packet handler
  input  wire codec_cfg_t  cfg,
  // transmit bytes from the tx fifo
  input  wire logic        tx_start,
  input  wire logic        tx_byte_valid,
  output logic             tx_byte_ready,
  input  wire logic [7:0]  tx_byte,
  // transmit bit stream to the modem
  input  wire logic        tx_tick,
  output logic             tx_bit,
  output logic             tx_bit_valid,
  output logic             tx_done,
  // receive bit stream from the modem
  input  wire logic        rx_start,
  input  wire logic        rx_tick,
  input  wire logic        rx_bit,
  // receive bytes to the rx fifo
  output logic             rx_byte_valid,
  output logic [7:0]       rx_byte,
  output logic             rx_done
);
  logic            fifo_valid, fifo_ready;
  logic [7:0]      fifo_data;

  byte_fifo #(.WIDTH(BYTE_W), .DEPTH(TX_FIFO_DEPTH)) tx_queue (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (tx_byte_valid),
    .in_ready  (tx_byte_ready),
    .in_data   (tx_byte),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // transmit state
  tx_state_t       tx_state, next_tx_state;
  logic            tx_coded, next_tx_coded;
  logic [7:0]      tx_len, next_tx_len;
  logic [8:0]      tx_target, next_tx_target, tx_loaded, next_tx_loaded;
  logic [15:0]     tx_mat, next_tx_mat;
  logic [4:0]      tx_idx, next_tx_idx, tx_nbits, next_tx_nbits;
  logic [2:0]      tx_enc, next_tx_enc, enc_st;
  logic            next_tx_bit, next_tx_bit_valid, next_tx_done;
  logic [7:0]      load_byte;
  logic            u_in;
  logic            use_code;

  always_comb begin
    next_tx_state     = tx_state;
    next_tx_coded     = tx_coded;
    next_tx_len       = tx_len;
    next_tx_target    = tx_target;
    next_tx_loaded    = tx_loaded;
    next_tx_mat       = tx_mat;
    next_tx_idx       = tx_idx;
    next_tx_nbits     = tx_nbits;
    next_tx_enc       = tx_enc;
    next_tx_bit       = tx_bit;
    next_tx_bit_valid = tx_bit_valid;
    next_tx_done      = 1'b0;
    fifo_ready        = 1'b0;
    load_byte         = fifo_data;
    enc_st            = tx_enc;
    u_in              = 1'b0;
    use_code = cfg.enable && (cfg.length_mode == LEN_FIXED);
    case (tx_state)
      TX_IDLE: begin
        if (tx_tick) begin
          next_tx_bit_valid = 1'b0;
        end
      end
      TX_LOAD: begin
        if (tx_tick) begin
          next_tx_bit_valid = 1'b0;
        end
        if (tx_loaded == tx_target) begin
          next_tx_state = TX_DONE;
        end else if (tx_loaded >= {1'b0, tx_len} || fifo_valid) begin
          if (tx_loaded < {1'b0, tx_len}) begin
            fifo_ready = 1'b1;
          end else begin
            load_byte = PAD_BYTE;
          end
          for (int i = 0; i < 8; i++) begin
            u_in = load_byte[7-i];
            if (tx_coded) begin
              // two coded bits per input bit
              // coder output filled row by row
              next_tx_mat[2*i]   = coded_bit({u_in, enc_st}, POLY_A);
              next_tx_mat[2*i+1] = coded_bit({u_in, enc_st}, POLY_B);
            end else begin
              next_tx_mat[i]   = u_in;
              next_tx_mat[i+8] = 1'b0;
            end
            enc_st = {u_in, enc_st[2:1]};
          end
          next_tx_enc    = enc_st;
          next_tx_nbits  = tx_coded ? CODED_BITS : PLAIN_BITS;
          next_tx_idx    = '0;
          next_tx_loaded = tx_loaded + 9'h001;
          next_tx_state  = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_tick) begin
          next_tx_bit = tx_coded ? tx_mat[column_read(tx_idx[3:0])]
                                 : tx_mat[tx_idx[3:0]];
          next_tx_bit_valid = 1'b1;
          next_tx_idx       = tx_idx + 5'h01;
          if (tx_idx == tx_nbits - 5'h01) begin
            next_tx_state = TX_LOAD;
          end
        end
      end
      TX_DONE: begin
        next_tx_done  = 1'b1;
        next_tx_state = TX_IDLE;
      end
      default: next_tx_state = TX_IDLE;
    endcase
    if (tx_start) begin
      next_tx_state  = TX_LOAD;
      next_tx_coded  = use_code;
      next_tx_len    = cfg.length;
      // one or two pads make an even total
      next_tx_target = use_code ? {1'b0, cfg.length}
                         + (cfg.length[0] ? 9'h001 : 9'h002)
                         : {1'b0, cfg.length};
      next_tx_loaded = '0;
      next_tx_mat    = '0;
      next_tx_idx    = '0;
      next_tx_enc    = '0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_state     <= TX_IDLE;
      tx_coded     <= 1'b0;
      tx_len       <= '0;
      tx_target    <= '0;
      tx_loaded    <= '0;
      tx_mat       <= '0;
      tx_idx       <= '0;
      tx_nbits     <= '0;
      tx_enc       <= '0;
      tx_bit       <= 1'b0;
      tx_bit_valid <= 1'b0;
      tx_done      <= 1'b0;
    end else begin
      tx_state     <= next_tx_state;
      tx_coded     <= next_tx_coded;
      tx_len       <= next_tx_len;
      tx_target    <= next_tx_target;
      tx_loaded    <= next_tx_loaded;
      tx_mat       <= next_tx_mat;
      tx_idx       <= next_tx_idx;
      tx_nbits     <= next_tx_nbits;
      tx_enc       <= next_tx_enc;
      tx_bit       <= next_tx_bit;
      tx_bit_valid <= next_tx_bit_valid;
      tx_done      <= next_tx_done;
    end
  end

  // receive state
  rx_state_t       rx_state, next_rx_state;
  logic            rx_coded, next_rx_coded;
  logic [7:0]      rx_len, next_rx_len;
  logic [8:0]      rx_target, next_rx_target, rx_coll, next_rx_coll;
  logic [8:0]      rx_dec, next_rx_dec;
  logic [15:0]     rx_mat, next_rx_mat;
  logic [3:0]      rx_sym, next_rx_sym, rx_flush, next_rx_flush;
  logic [2:0]      rx_step, next_rx_step, rx_acc_cnt, next_rx_acc_cnt;
  logic [4:0]      rx_warm, next_rx_warm;
  logic [7:0]      rx_acc, next_rx_acc, next_rx_byte;
  logic            next_rx_byte_valid, next_rx_done;
  logic [7:0]      metric [NSTATES];
  logic [7:0]      next_metric [NSTATES];
  logic [7:0]      cand [NSTATES];
  logic [15:0]     surv [NSTATES];
  logic [15:0]     next_surv [NSTATES];
  logic [7:0]      m0, m1, cmin;
  logic [2:0]      best, ns3, p0, p1;
  logic            r0, r1, emit, emit_bit;

  function automatic logic [7:0] branch_cost(input logic [2:0] pred,
      input logic u, input logic a, input logic b);
    return {7'h00, coded_bit({u, pred}, POLY_A) ^ a}
         + {7'h00, coded_bit({u, pred}, POLY_B) ^ b};
  endfunction

  always_comb begin
    next_rx_state      = rx_state;
    next_rx_coded      = rx_coded;
    next_rx_len        = rx_len;
    next_rx_target     = rx_target;
    next_rx_coll       = rx_coll;
    next_rx_dec        = rx_dec;
    next_rx_mat        = rx_mat;
    next_rx_sym        = rx_sym;
    next_rx_flush      = rx_flush;
    next_rx_step       = rx_step;
    next_rx_acc_cnt    = rx_acc_cnt;
    next_rx_warm       = rx_warm;
    next_rx_acc        = rx_acc;
    next_rx_byte       = rx_byte;
    next_rx_byte_valid = 1'b0;
    next_rx_done       = 1'b0;
    next_metric        = metric;
    next_surv          = surv;
    emit               = 1'b0;
    emit_bit           = 1'b0;
    m0                 = '0;
    m1                 = '0;
    p0                 = '0;
    p1                 = '0;
    // decoder pair read down the columns
    r0 = rx_mat[column_read({rx_step, 1'b0})];
    r1 = rx_mat[column_read({rx_step, 1'b1})];
    best = '0;
    cmin = 8'hFF;
    for (int s = 0; s < NSTATES; s++) begin
      if (metric[s] < metric[best]) begin
        best = 3'(s);
      end
    end
    for (int ns = 0; ns < NSTATES; ns++) begin
      ns3 = 3'(ns);
      p0  = {ns3[1:0], 1'b0};
      p1  = {ns3[1:0], 1'b1};
      m0  = metric[p0] + branch_cost(p0, ns3[2], r0, r1);
      m1  = metric[p1] + branch_cost(p1, ns3[2], r0, r1);
      cand[ns] = (m1 < m0) ? m1 : m0;
      next_surv[ns] = (m1 < m0) ? {surv[p1][14:0], ns3[2]}
                                : {surv[p0][14:0], ns3[2]};
      if (cand[ns] < cmin) begin
        cmin = cand[ns];
      end
    end
    case (rx_state)
      RX_COLLECT: begin
        next_surv = surv;
        if (!rx_coded && rx_dec == {1'b0, rx_len}) begin
          next_rx_state = RX_DONE;
        end else if (rx_tick) begin
          if (rx_coded) begin
            next_rx_mat[rx_sym] = rx_bit;
            next_rx_sym = rx_sym + 4'h1;
            if (rx_sym == LAST_SYMBOL) begin
              next_rx_step  = '0;
              next_rx_coll  = rx_coll + 9'h001;
              next_rx_state = RX_DECODE;
            end
          end else begin
            emit     = 1'b1;
            emit_bit = rx_bit;
          end
        end
      end
      RX_DECODE: begin
        // new metrics are dropped by their common minimum to stay small
        for (int s = 0; s < NSTATES; s++) begin
          next_metric[s] = cand[s] - cmin;
        end
        if (rx_warm == SURV_FULL) begin
          emit     = 1'b1;
          emit_bit = surv[best][SURV_LEN-1];
        end else begin
          next_rx_warm = rx_warm + 5'h01;
        end
        next_rx_step = rx_step + 3'h1;
        if (rx_step == LAST_PAIR) begin
          next_rx_state = (rx_coll == rx_target) ? RX_FLUSH : RX_COLLECT;
        end
      end
      RX_FLUSH: begin
        // zero pad returns the coder to state 0, so trace from there
        next_surv     = surv;
        emit          = 1'b1;
        emit_bit      = surv[0][LAST_FLUSH - rx_flush];
        next_rx_flush = rx_flush + 4'h1;
        if (rx_flush == LAST_FLUSH) begin
          next_rx_state = RX_DONE;
        end
      end
      RX_DONE: begin
        next_surv     = surv;
        next_rx_done  = 1'b1;
        next_rx_state = RX_IDLE;
      end
      default: begin
        next_surv     = surv;
        next_rx_state = RX_IDLE;
      end
    endcase
    if (emit) begin
      next_rx_acc     = {rx_acc[6:0], emit_bit};
      next_rx_acc_cnt = rx_acc_cnt + 3'h1;
      if (rx_acc_cnt == LAST_BIT) begin
        // bytes past the field are pad and dropped
        if (rx_dec < {1'b0, rx_len}) begin
          next_rx_byte_valid = 1'b1;
          next_rx_byte       = {rx_acc[6:0], emit_bit};
        end
        next_rx_dec = rx_dec + 9'h001;
      end
    end
    if (rx_start) begin
      next_rx_state   = RX_COLLECT;
      // whole field plus pad passes the decoder
      next_rx_coded   = use_code;
      next_rx_len     = cfg.length;
      next_rx_target  = {1'b0, cfg.length}
                        + (cfg.length[0] ? 9'h001 : 9'h002);
      next_rx_coll    = '0;
      next_rx_dec     = '0;
      next_rx_mat     = '0;
      next_rx_sym     = '0;
      next_rx_flush   = '0;
      next_rx_step    = '0;
      next_rx_acc_cnt = '0;
      next_rx_warm    = '0;
      next_rx_acc     = '0;
      for (int s = 0; s < NSTATES; s++) begin
        next_metric[s] = (s == 0) ? METRIC_START : METRIC_FAR;
        next_surv[s]   = '0;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_state      <= RX_IDLE;
      rx_coded      <= 1'b0;
      rx_len        <= '0;
      rx_target     <= '0;
      rx_coll       <= '0;
      rx_dec        <= '0;
      rx_mat        <= '0;
      rx_sym        <= '0;
      rx_flush      <= '0;
      rx_step       <= '0;
      rx_acc_cnt    <= '0;
      rx_warm       <= '0;
      rx_acc        <= '0;
      rx_byte       <= '0;
      rx_byte_valid <= 1'b0;
      rx_done       <= 1'b0;
      for (int s = 0; s < NSTATES; s++) begin
        metric[s] <= METRIC_START;
        surv[s]   <= '0;
      end
    end else begin
      rx_state      <= next_rx_state;
      rx_coded      <= next_rx_coded;
      rx_len        <= next_rx_len;
      rx_target     <= next_rx_target;
      rx_coll       <= next_rx_coll;
      rx_dec        <= next_rx_dec;
      rx_mat        <= next_rx_mat;
      rx_sym        <= next_rx_sym;
      rx_flush      <= next_rx_flush;
      rx_step       <= next_rx_step;
      rx_acc_cnt    <= next_rx_acc_cnt;
      rx_warm       <= next_rx_warm;
      rx_acc        <= next_rx_acc;
      rx_byte       <= next_rx_byte;
      rx_byte_valid <= next_rx_byte_valid;
      rx_done       <= next_rx_done;
      metric        <= next_metric;
      surv          <= next_surv;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_enable_gate: assert property (tx_start |=> tx_coded ==
    ($past(cfg.enable) && $past(cfg.length_mode) == LEN_FIXED))
    else $error("tx coding does not follow enable");
  a_fixed_mode_only: assert property (rx_start && cfg.length_mode !=
    LEN_FIXED |=> !rx_coded) else $error("rx coded outside fixed mode");
  a_field_all_decoded: assert property (rx_state == RX_FLUSH
    |-> rx_coll == rx_target) else $error("flush before field decoded");
  a_rate_half: assert property (tx_state == TX_SEND && tx_coded
    |-> tx_nbits == CODED_BITS) else $error("coded byte not 16 bits");
  a_matrix_bound: assert property (tx_state == TX_SEND
    |-> tx_idx < CODED_BITS) else $error("matrix index out of range");
  a_column_order: assert property (tx_state == TX_SEND && tx_coded
    && tx_tick && tx_idx == 5'h01 |=> tx_bit == $past(tx_mat[4]))
    else $error("second air bit not first column");
  a_decode_span: assert property ($rose(rx_state == RX_DECODE)
    |-> (rx_state == RX_DECODE)[*8] ##1 rx_state != RX_DECODE)
    else $error("decode does not take eight cycles");
  a_pad_even: assert property (tx_state == TX_DONE && tx_coded
    |-> !tx_loaded[0] && tx_loaded > {1'b0, tx_len}
        && tx_loaded <= {1'b0, tx_len} + 9'h002)
    else $error("pad count wrong");
  a_pad_hidden: assert property (rx_byte_valid
    |-> rx_dec <= {1'b0, rx_len}) else $error("pad byte delivered");
  a_start_clears: assert property (tx_start |=> tx_loaded == '0
    && tx_enc == '0 && tx_state == TX_LOAD) else $error("start not clean");

  c_tx_coded: cover property (tx_state == TX_DONE && tx_coded);
  c_tx_plain: cover property (tx_state == TX_DONE && !tx_coded);
  c_rx_coded: cover property (rx_done && rx_coded);
  c_rx_plain: cover property (rx_done && !rx_coded);
endmodule

`default_nettype wire

// [test/modem_partner.sv]
// modem-side model: strobes air bits out of the encoder and replays them in
`timescale 1ns/1ns
`default_nettype none
module modem_partner (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // transmit air side
  output logic      tx_tick,
  input  wire logic tx_bit,
  input  wire logic tx_bit_valid,
  input  wire logic tx_done,
  // receive air side
  output logic      rx_start,
  output logic      rx_tick,
  output logic      rx_bit
);
  logic air[$];
  logic done_seen;

  initial begin
    tx_tick = 1'b0;
    rx_start = 1'b0;
    rx_tick = 1'b0;
    rx_bit = 1'b0;
    done_seen = 1'b0;
  end

  always @(posedge mclk) begin
    if (reset) begin
      done_seen <= 1'b0;
    end else if (tx_done === 1'b1) begin
      done_seen <= 1'b1;
    end
  end

  // one strobe, then gap plus one idle cycles; strobes that find no bit add nothing
  task automatic capture(input int gap);
    int n;
    air.delete();
    done_seen = 1'b0;
    n = 0;
    while (done_seen !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      tx_tick <= 1'b1;
      @(posedge mclk);
      tx_tick <= 1'b0;
      #1;
      if (tx_bit_valid === 1'b1) air.push_back(tx_bit);
      repeat (gap) @(posedge mclk);
      n++;
    end
  endtask

  // strobes 12 cycles apart so none lands in a decode burst
  task automatic play(input int flip);
    @(posedge mclk);
    rx_start <= 1'b1;
    @(posedge mclk);
    rx_start <= 1'b0;
    foreach (air[i]) begin
      repeat (11) @(posedge mclk);
      rx_tick <= 1'b1;
      rx_bit  <= air[i] ^ (i == flip);
      @(posedge mclk);
      rx_tick <= 1'b0;
      // undriven between strobes: show the opposite level, not a held one
      rx_bit  <= ~(air[i] ^ (i == flip));
    end
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench: coded and plain packets looped through the modem model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fec_codec_pkg::*;
  logic       mclk, reset, tx_start, tx_byte_valid, tx_byte_ready;
  logic       tx_tick, tx_bit, tx_bit_valid, tx_done;
  logic       rx_start, rx_tick, rx_bit, rx_byte_valid, rx_done;
  logic [7:0] tx_byte, rx_byte;
  codec_cfg_t cfg;
  int         err_total, n_tests, seed;
  logic [7:0] data[$], got[$];
  logic       exp_air[$];
  logic       rx_seen, saw_full;

  fec_interleave_codec fec_interleave_codec_inst (
    .mclk(mclk), .reset(reset), .cfg(cfg), .tx_start(tx_start),
    .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
    .tx_byte(tx_byte), .tx_tick(tx_tick), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .tx_done(tx_done), .rx_start(rx_start),
    .rx_tick(rx_tick), .rx_bit(rx_bit), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_done(rx_done));

  modem_partner modem_partner_inst (
    .mclk(mclk), .reset(reset), .tx_tick(tx_tick), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .tx_done(tx_done), .rx_start(rx_start),
    .rx_tick(rx_tick), .rx_bit(rx_bit));

  always #25 mclk = ~mclk;

  always @(posedge mclk) begin
    if (rx_byte_valid === 1'b1) got.push_back(rx_byte);
    if (rx_done === 1'b1) rx_seen <= 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want,
                       input string what);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // reference coder: window {u,s}, rows written, columns sent
  task automatic build(input bit coded);
    logic [2:0] s;
    logic [3:0] w;
    logic [7:0] b;
    logic       c[16];
    int         nb;
    exp_air.delete();
    s = 3'h0;
    nb = coded ? data.size() + ((data.size() % 2) ? 1 : 2) : data.size();
    for (int k = 0; k < nb; k++) begin
      b = (k < data.size()) ? data[k] : PAD_BYTE;
      for (int i = 0; i < 8; i++) begin
        w = {b[7-i], s};
        c[2*i] = ^(w & POLY_A_DEF);
        c[2*i+1] = ^(w & POLY_B_DEF);
        s = w[3:1];
        if (!coded) exp_air.push_back(b[7-i]);
      end
      for (int j = 0; j < 16 && coded; j++) exp_air.push_back(c[(j%4)*4+j/4]);
    end
  endtask

  // ready is read settled after the edge; it is low only while the buffer holds four bytes
  task automatic push_all();
    foreach (data[i]) begin
      tx_byte_valid <= 1'b1;
      tx_byte       <= data[i];
      #1;
      while (tx_byte_ready !== 1'b1) begin
        saw_full = 1'b1;
        @(posedge mclk);
        #1;
      end
      @(posedge mclk);
    end
    tx_byte_valid <= 1'b0;
  endtask

  task automatic run(input bit en, input logic [1:0] mode, input int len,
                     input int gap, input int flip);
    bit coded;
    int nbits;
    logic air_q[$];
    data.delete();
    for (int i = 0; i < len; i++) data.push_back(8'($random(seed)));
    coded = en && mode == LEN_FIXED;
    build(coded);
    cfg <= '{enable: en, length_mode: mode, length: 8'(len)};
    saw_full = 1'b0;
    @(posedge mclk);
    tx_start <= 1'b1;
    @(posedge mclk);
    tx_start <= 1'b0;
    fork
      push_all();
      begin
        // modem stalls while the input buffer fills
        repeat (30) @(posedge mclk);
        modem_partner_inst.capture(gap);
      end
    join
    air_q = modem_partner_inst.air;
    check(modem_partner_inst.done_seen, 1'b1, "no end of send");
    nbits = coded ? exp_air.size() : len * 8;
    if (coded) begin
      check(16'(air_q.size()), 16'(nbits), "air count");
    end
    for (int i = 0; i < nbits; i++) begin
      check(air_q[i], exp_air[i], "air bit");
    end
    if (len >= 6) check(saw_full, 1'b1, "buffer never refused");
    got.delete();
    rx_seen = 1'b0;
    modem_partner_inst.play(flip);
    for (int t = 0; t < 3000 && rx_seen !== 1'b1; t++) @(posedge mclk);
    check(rx_seen, 1'b1, "no end of receive");
    check(16'(got.size()), 16'(len), "rx byte count");
    foreach (data[i]) check(got[i], data[i], "rx byte");
  endtask

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    cfg = '0;
    tx_start = 1'b0;
    tx_byte_valid = 1'b0;
    tx_byte = 8'h00;
    seed = 56;
    err_total = 0;
    n_tests = 0;
    rx_seen = 1'b0;
    saw_full = 1'b0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    // coded payloads are never shorter than two bytes
    run(1'b1, LEN_FIXED, 2, 2, -1);
    run(1'b1, LEN_FIXED, 7, 2 + ($unsigned($random(seed)) % 6), -1);
    run(1'b1, LEN_FIXED, 6, 3, 21);
    run(1'b0, LEN_FIXED, 5, 2, -1);
    run(1'b1, 2'h1, 4, 2, -1);
    summarize();
  end

  initial begin
    #(40000 * 50);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
